// ==== cff_pkg.sv ====
// ========================================
// constants for the filter and fifo control block
// ========================================
package cff_pkg;

	// ========================================
	// sizes
	// ========================================
	localparam int FILTER_COUNT = 32;
	localparam int FIFO_COUNT   = 32;
	localparam int MASK_COUNT   = 4;
	localparam int ADDR_W       = 10;

	// ========================================
	// register map, byte addresses
	// ========================================
	localparam logic [2:0]        REGION_FILTER_VALUE   = 3'h0; // 0x000 + 4*n
	localparam logic [2:0]        REGION_FILTER_CONTROL = 3'h1; // 0x080 + 4*n
	localparam logic [2:0]        REGION_FIFO_CONTROL   = 3'h2; // 0x100 + 4*n
	localparam logic [2:0]        REGION_USER_ADDRESS   = 3'h3; // 0x180 + 4*n
	localparam logic [2:0]        REGION_MISC           = 3'h4;
	localparam logic [ADDR_W-1:0] BASE_ADDRESS_OFFSET   = 10'h200;
	localparam logic [ADDR_W-1:0] MASK_OFFSET_FIRST     = 10'h210; // 0x210..0x21C

	// ========================================
	// filter value and mask layout
	// ========================================
	localparam int SID_LSB         = 21;
	localparam int EXT_SELECT_BIT  = 19;
	localparam int EID_LSB         = 0;

	// ========================================
	// filter control layout
	// ========================================
	localparam int FILTER_ENABLE_BIT = 7;
	localparam int MASK_SELECT_LSB          = 5;
	localparam int DESTINATION_FIFO_SELECT_LSB          = 0;

	// ========================================
	// fifo control layout
	// ========================================
	localparam int DEPTH_LSB        = 16;
	localparam int RESET_BIT        = 14;
	localparam int INCR_BIT         = 13;
	localparam int PAYLOAD_ONLY_BIT = 12;
	localparam int DIRECTION_BIT    = 7;
	localparam int ABORTED_BIT      = 6;
	localparam int ARB_LOST_BIT     = 5;
	localparam int TX_ERROR_BIT     = 4;
	localparam int TRANSMIT_REQUEST_BIT_BIT        = 3;
	localparam int RTR_ENABLE_BIT   = 2;
	localparam int PRIORITY_LSB     = 0;

	// ========================================
	// mode, alignment and message sizes
	// ========================================
	localparam logic [2:0]  CONFIG_MODE        = 3'h4;
	localparam logic [31:0] BASE_WRITABLE_MASK = 32'hFFFF_FFFC;
	localparam logic [31:0] BASE_RESET         = 32'h0000_0000;
	localparam logic [31:0] FULL_MSG_BYTES     = 32'h0000_0010;
	localparam logic [31:0] DATA_ONLY_BYTES    = 32'h0000_0008;

	// merge a bus write into an old word by byte lane
	function automatic logic [31:0] cff_merge(input logic [31:0] old_word,
		input logic [31:0] new_word, input logic [3:0] sel);
		logic [31:0] lane;
		lane = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (new_word & lane) | (old_word & ~lane);
	endfunction : cff_merge

endpackage : cff_pkg

// ==== cff_filter_match.sv ====
`timescale 1ns/1ns
`default_nettype none
// ========================================
// one acceptance filter comparator
// ========================================
module cff_filter_match (
	input  wire logic        enable,
	input  wire logic        ext_select,
	input  wire logic [10:0] value_sid,
	input  wire logic [17:0] value_eid,
	input  wire logic [10:0] mask_sid,
	input  wire logic [17:0] mask_eid,
	input  wire logic        msg_ide,
	input  wire logic [10:0] msg_sid,
	input  wire logic [17:0] msg_eid,
	output logic             hit
);
	logic sid_equal;
	logic eid_equal;

	// masked compare, zero mask bits are don't-care
	assign sid_equal = ((value_sid ^ msg_sid) & mask_sid) == 11'h000;
	assign eid_equal = ((value_eid ^ msg_eid) & mask_eid) == 18'h00000;

	// frame type must agree with the filter's extended select
	assign hit = enable & (msg_ide == ext_select) & sid_equal & (~msg_ide | eid_equal);
endmodule : cff_filter_match
`default_nettype wire

// ==== cff_filter_fifo_control.sv ====
`timescale 1ns/1ns
`default_nettype none
module cff_filter_fifo_control
	import cff_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic [2:0]        operating_mode_field,
	input  wire logic              rx_valid,
	input  wire logic              rx_ide,
	input  wire logic              rx_rtr,
	input  wire logic [10:0]       rx_sid,
	input  wire logic [17:0]       rx_eid,
	output logic                   rx_store_valid,
	output logic      [4:0]        rx_store_fifo,
	output logic      [31:0]       rx_store_addr,
	output logic                   rx_store_payload_only,
	output logic                   rx_overflow,
	output logic                   tx_offer_valid,
	output logic      [4:0]        tx_offer_fifo,
	output logic      [31:0]       tx_offer_addr,
	output logic      [31:0]       tx_abort_request,
	input  wire logic [4:0]        tx_status_fifo,
	input  wire logic              tx_success,
	input  wire logic              tx_aborted,
	input  wire logic              tx_arb_lost,
	input  wire logic              tx_bus_error
);
	// ========================================
	// storage
	// ========================================
	logic [10:0]           flt_sid   [FILTER_COUNT];
	logic [17:0]           flt_eid   [FILTER_COUNT];
	logic [1:0]            flt_mask_select  [FILTER_COUNT];
	logic [4:0]            flt_destination_fifo_select  [FILTER_COUNT];
	logic [FILTER_COUNT-1:0] flt_ext;
	logic [FILTER_COUNT-1:0] flt_en;
	logic [10:0]           mask_sid  [MASK_COUNT];
	logic [17:0]           mask_eid  [MASK_COUNT];
	logic [31:0]           base_addr;
	logic [4:0]            fifo_depth [FIFO_COUNT];
	logic [1:0]            fifo_prio  [FIFO_COUNT];
	logic [4:0]            head       [FIFO_COUNT];
	logic [4:0]            tail       [FIFO_COUNT];
	logic [5:0]            count      [FIFO_COUNT];
	logic [FIFO_COUNT-1:0] fifo_payload_only;
	logic [FIFO_COUNT-1:0] fifo_dir;
	logic [FIFO_COUNT-1:0] fifo_rtr_en;
	logic [FIFO_COUNT-1:0] fifo_reset_bit;
	logic [FIFO_COUNT-1:0] fifo_transmit_request_bit;
	logic [FIFO_COUNT-1:0] abort_pending;
	logic [FIFO_COUNT-1:0] fifo_aborted;
	logic [FIFO_COUNT-1:0] fifo_arb_lost;
	logic [FIFO_COUNT-1:0] fifo_tx_error;

	// ========================================
	// bus decode
	// ========================================
	logic        bus_take;
	logic        bus_wr;
	logic        bus_rd;
	logic [2:0]  region;
	logic [4:0]  idx;
	logic        config_mode;
	logic [31:0] read_word;
	logic [31:0] fc_read;
	logic [31:0] fc_merged;
	logic [31:0] fv_merged;
	logic [31:0] fk_merged;
	logic        fc_wr;
	logic        fc_rd;
	logic        is_base;
	logic        is_mask;

	// one request taken per bus cycle, ack follows one cycle later
	assign bus_take    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr      = bus_take & wb_we_i;
	assign bus_rd      = bus_take & ~wb_we_i;
	assign region      = wb_adr_i[9:7];
	assign idx         = wb_adr_i[6:2];
	assign config_mode = operating_mode_field == CONFIG_MODE;
	assign is_base     = wb_adr_i == BASE_ADDRESS_OFFSET;
	assign is_mask     = wb_adr_i[ADDR_W-1:4] == MASK_OFFSET_FIRST[ADDR_W-1:4];
	assign fc_wr       = bus_wr & (region == REGION_FIFO_CONTROL);
	assign fc_rd       = bus_rd & (region == REGION_FIFO_CONTROL);

	// fifo control readback; increment always reads zero
	assign fc_read = {11'h000, fifo_depth[idx], 1'b0, fifo_reset_bit[idx], 1'b0,
		fifo_payload_only[idx], 4'h0, fifo_dir[idx], fifo_aborted[idx],
		fifo_arb_lost[idx], fifo_tx_error[idx], fifo_transmit_request_bit[idx], fifo_rtr_en[idx],
		fifo_prio[idx]};
	assign fc_merged = cff_merge(fc_read, wb_dat_i, wb_sel_i);
	assign fv_merged = cff_merge(read_word, wb_dat_i, wb_sel_i);
	assign fk_merged = cff_merge(read_word, wb_dat_i, wb_sel_i);

	// ========================================
	// message area placement
	// ========================================
	logic [31:0] slot_bytes  [FIFO_COUNT];
	logic [31:0] area_offset [FIFO_COUNT];
	logic [31:0] user_addr   [FIFO_COUNT];

	// each area starts where the lower-numbered ones end
	always_comb begin
		logic [31:0] acc;
		acc = 32'h0000_0000;
		for (int i = 0; i < FIFO_COUNT; i++) begin
			slot_bytes[i]  = (!fifo_dir[i] && fifo_payload_only[i]) ? DATA_ONLY_BYTES
				: FULL_MSG_BYTES;
			area_offset[i] = acc;
			acc = acc + {26'h0, 6'({1'b0, fifo_depth[i]} + 6'h01)} * slot_bytes[i];
			user_addr[i]   = base_addr + area_offset[i]
				+ {27'h0, (fifo_dir[i] ? head[i] : tail[i])} * slot_bytes[i];
		end
	end

	// register readback mux; unmapped addresses read zero
	always_comb begin
		read_word = 32'h0000_0000;
		case (region)
			REGION_FILTER_VALUE: read_word = {flt_sid[idx], 1'b0, flt_ext[idx], 1'b0,
				flt_eid[idx]};
			REGION_FILTER_CONTROL: read_word = {24'h000000, flt_en[idx], flt_mask_select[idx],
				flt_destination_fifo_select[idx]};
			REGION_FIFO_CONTROL: read_word = fc_read;
			REGION_USER_ADDRESS: read_word = user_addr[idx];
			REGION_MISC: begin
				if (is_base) begin
					read_word = base_addr;
				end else if (is_mask) begin
					read_word = {mask_sid[wb_adr_i[3:2]], 3'h0, mask_eid[wb_adr_i[3:2]]};
				end
			end
			default: read_word = 32'h0000_0000;
		endcase
	end

	// bus answer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_take;
			wb_dat_o <= bus_rd ? read_word : 32'h0000_0000;
		end
	end

	// base address, config mode only, low bits forced zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			base_addr <= BASE_RESET;
		end else if (bus_wr && region == REGION_MISC && is_base && config_mode) begin
			base_addr <= cff_merge(base_addr, wb_dat_i, wb_sel_i) & BASE_WRITABLE_MASK;
		end
	end

	// ========================================
	// acceptance filters and masks
	// ========================================
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flt_en  <= '0;
			flt_ext <= '0;
			for (int i = 0; i < FILTER_COUNT; i++) begin
				flt_sid[i]  <= 11'h000;
				flt_eid[i]  <= 18'h00000;
				flt_mask_select[i] <= 2'h0;
				flt_destination_fifo_select[i] <= 5'h00;
			end
			for (int m = 0; m < MASK_COUNT; m++) begin
				mask_sid[m] <= 11'h000;
				mask_eid[m] <= 18'h00000;
			end
		end else if (bus_wr) begin
			// value fields change only while the filter is off
			if (region == REGION_FILTER_VALUE && !flt_en[idx]) begin
				flt_sid[idx] <= fv_merged[SID_LSB +: 11];
				flt_ext[idx] <= fv_merged[EXT_SELECT_BIT];
				flt_eid[idx] <= fv_merged[EID_LSB +: 18];
			end
			if (region == REGION_FILTER_CONTROL) begin
				flt_en[idx] <= fv_merged[FILTER_ENABLE_BIT];
				if (!flt_en[idx]) begin
					flt_mask_select[idx] <= fv_merged[MASK_SELECT_LSB +: 2];
					flt_destination_fifo_select[idx] <= fv_merged[DESTINATION_FIFO_SELECT_LSB +: 5];
				end
			end
			if (region == REGION_MISC && is_mask) begin
				mask_sid[wb_adr_i[3:2]] <= fk_merged[SID_LSB +: 11];
				mask_eid[wb_adr_i[3:2]] <= fk_merged[EID_LSB +: 18];
			end
		end
	end

	// ========================================
	// receive matching
	// ========================================
	logic [FILTER_COUNT-1:0] filter_hit;
	logic                    hit_any;
	logic [4:0]              hit_filter;
	logic [4:0]              dest;
	logic                    dest_full;
	logic                    rx_push;
	logic                    rx_full_drop;
	logic                    rx_rtr_set;

	for (genvar g = 0; g < FILTER_COUNT; g++) begin : g_filter
		cff_filter_match u_match (
			.enable     (flt_en[g]),
			.ext_select (flt_ext[g]),
			.value_sid  (flt_sid[g]),
			.value_eid  (flt_eid[g]),
			.mask_sid   (mask_sid[flt_mask_select[g]]),
			.mask_eid   (mask_eid[flt_mask_select[g]]),
			.msg_ide    (rx_ide),
			.msg_sid    (rx_sid),
			.msg_eid    (rx_eid),
			.hit        (filter_hit[g])
		);
	end

	// lowest-numbered hitting filter decides the destination
	always_comb begin
		hit_filter = 5'h00;
		for (int i = FILTER_COUNT - 1; i >= 0; i--) begin
			if (filter_hit[i]) begin
				hit_filter = 5'(i);
			end
		end
	end

	assign hit_any      = rx_valid & (|filter_hit);
	assign dest         = flt_destination_fifo_select[hit_filter];
	assign dest_full    = count[dest] == 6'({1'b0, fifo_depth[dest]} + 6'h01);
	assign rx_push      = hit_any & ~fifo_dir[dest] & ~dest_full & ~fifo_reset_bit[dest];
	assign rx_full_drop = hit_any & ~fifo_dir[dest] & dest_full;
	assign rx_rtr_set   = hit_any & rx_rtr & fifo_dir[dest] & fifo_rtr_en[dest];

	// store request towards the message writer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_store_valid        <= 1'b0;
			rx_store_fifo         <= 5'h00;
			rx_store_addr         <= 32'h0000_0000;
			rx_store_payload_only <= 1'b0;
			rx_overflow           <= 1'b0;
		end else begin
			rx_store_valid <= rx_push;
			rx_overflow    <= rx_full_drop;
			if (rx_push) begin
				rx_store_fifo         <= dest;
				rx_store_addr         <= base_addr + area_offset[dest]
					+ {27'h0, head[dest]} * slot_bytes[dest];
				rx_store_payload_only <= fifo_payload_only[dest];
			end
		end
	end

	// ========================================
	// fifo configuration
	// ========================================
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fifo_payload_only <= '0;
			fifo_dir          <= '0;
			fifo_rtr_en       <= '0;
			for (int i = 0; i < FIFO_COUNT; i++) begin
				fifo_depth[i] <= 5'h00;
				fifo_prio[i]  <= 2'h0;
			end
		end else if (fc_wr) begin
			fifo_dir[idx]    <= fc_merged[DIRECTION_BIT];
			fifo_rtr_en[idx] <= fc_merged[RTR_ENABLE_BIT];
			fifo_prio[idx]   <= fc_merged[PRIORITY_LSB +: 2];
			if (config_mode) begin
				fifo_depth[idx]        <= fc_merged[DEPTH_LSB +: 5];
				fifo_payload_only[idx] <= fc_merged[PAYLOAD_ONLY_BIT];
			end
		end
	end

	// ========================================
	// pointers
	// ========================================
	logic [FIFO_COUNT-1:0] fifo_push;
	logic [FIFO_COUNT-1:0] fifo_pop;
	logic [FIFO_COUNT-1:0] sw_incr;
	logic [FIFO_COUNT-1:0] ev_success;
	logic [FIFO_COUNT-1:0] ev_aborted;

	// per-fifo events; increment meaning follows the direction
	always_comb begin
		for (int i = 0; i < FIFO_COUNT; i++) begin
			sw_incr[i]    = fc_wr & (idx == 5'(i)) & fc_merged[INCR_BIT];
			ev_success[i] = tx_success & (tx_status_fifo == 5'(i)) & fifo_dir[i];
			ev_aborted[i] = tx_aborted & (tx_status_fifo == 5'(i)) & fifo_dir[i];
			if (fifo_dir[i]) begin
				fifo_push[i] = sw_incr[i]
					& (count[i] != 6'({1'b0, fifo_depth[i]} + 6'h01));
				fifo_pop[i]  = ev_success[i] & (count[i] != 6'h00);
			end else begin
				fifo_push[i] = rx_push & (dest == 5'(i));
				fifo_pop[i]  = sw_incr[i] & (count[i] != 6'h00);
			end
		end
	end

	// head, tail and fill level, wrapping at the configured depth
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < FIFO_COUNT; i++) begin
				head[i]  <= 5'h00;
				tail[i]  <= 5'h00;
				count[i] <= 6'h00;
			end
		end else begin
			for (int i = 0; i < FIFO_COUNT; i++) begin
				if (fifo_reset_bit[i]) begin
					head[i]  <= 5'h00;
					tail[i]  <= 5'h00;
					count[i] <= 6'h00;
				end else begin
					if (fifo_push[i]) begin
						head[i] <= (head[i] == fifo_depth[i]) ? 5'h00 : head[i] + 5'h01;
					end
					if (fifo_pop[i]) begin
						tail[i] <= (tail[i] == fifo_depth[i]) ? 5'h00 : tail[i] + 5'h01;
					end
					count[i] <= count[i] + {5'h00, fifo_push[i]} - {5'h00, fifo_pop[i]};
				end
			end
		end
	end

	// ========================================
	// requests and transmit status
	// ========================================
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fifo_reset_bit <= '0;
			fifo_transmit_request_bit     <= '0;
			abort_pending  <= '0;
			fifo_aborted   <= '0;
			fifo_arb_lost  <= '0;
			fifo_tx_error  <= '0;
		end else begin
			for (int i = 0; i < FIFO_COUNT; i++) begin
				if (fifo_reset_bit[i]) begin
					// reset done this cycle, bit and flags fall together
					fifo_reset_bit[i] <= 1'b0;
					fifo_transmit_request_bit[i]     <= 1'b0;
					abort_pending[i]  <= 1'b0;
					fifo_aborted[i]   <= 1'b0;
					fifo_arb_lost[i]  <= 1'b0;
					fifo_tx_error[i]  <= 1'b0;
				end else begin
					if (fc_wr && idx == 5'(i) && fc_merged[RESET_BIT]) begin
						fifo_reset_bit[i] <= 1'b1;
					end
					// software request, completion, abort, then auto reply wins
					if (ev_aborted[i] || (ev_success[i] && count[i] == 6'h01)) begin
						fifo_transmit_request_bit[i] <= 1'b0;
					end else if (fc_wr && idx == 5'(i) && fifo_dir[i]) begin
						fifo_transmit_request_bit[i] <= fc_merged[TRANSMIT_REQUEST_BIT_BIT];
					end
					if (rx_rtr_set && dest == 5'(i)) begin
						fifo_transmit_request_bit[i] <= 1'b1;
					end
					// clearing a set request asks the engine to abort
					if (fc_wr && idx == 5'(i) && fifo_dir[i] && fifo_transmit_request_bit[i]
						&& !fc_merged[TRANSMIT_REQUEST_BIT_BIT]) begin
						abort_pending[i] <= 1'b1;
					end else if (ev_aborted[i] || ev_success[i]) begin
						abort_pending[i] <= 1'b0;
					end
					if (ev_aborted[i]) begin
						fifo_aborted[i] <= 1'b1;
					end else if (ev_success[i]) begin
						fifo_aborted[i] <= 1'b0;
					end
					// status events win over a clearing read
					if (tx_arb_lost && tx_status_fifo == 5'(i) && fifo_dir[i]) begin
						fifo_arb_lost[i] <= 1'b1;
					end else if (fc_rd && idx == 5'(i)) begin
						fifo_arb_lost[i] <= 1'b0;
					end
					if (tx_bus_error && tx_status_fifo == 5'(i) && fifo_dir[i]) begin
						fifo_tx_error[i] <= 1'b1;
					end else if (fc_rd && idx == 5'(i)) begin
						fifo_tx_error[i] <= 1'b0;
					end
				end
			end
		end
	end

	// ========================================
	// transmit arbitration
	// ========================================
	logic       best_valid;
	logic [4:0] best_fifo;
	logic [1:0] best_prio;

	// ascending scan with >= hands ties to the higher fifo
	always_comb begin
		best_valid = 1'b0;
		best_fifo  = 5'h00;
		best_prio  = 2'h0;
		for (int i = 0; i < FIFO_COUNT; i++) begin
			if (fifo_dir[i] && fifo_transmit_request_bit[i] && count[i] != 6'h00 && !abort_pending[i]
				&& !fifo_reset_bit[i] && (!best_valid || fifo_prio[i] >= best_prio)) begin
				best_valid = 1'b1;
				best_fifo  = 5'(i);
				best_prio  = fifo_prio[i];
			end
		end
	end

	// offered message and abort requests towards the engine
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_offer_valid   <= 1'b0;
			tx_offer_fifo    <= 5'h00;
			tx_offer_addr    <= 32'h0000_0000;
			tx_abort_request <= 32'h0000_0000;
		end else begin
			tx_offer_valid   <= best_valid;
			tx_offer_fifo    <= best_fifo;
			tx_offer_addr    <= base_addr + area_offset[best_fifo]
				+ {27'h0, tail[best_fifo]} * slot_bytes[best_fifo];
			tx_abort_request <= abort_pending;
		end
	end
endmodule : cff_filter_fifo_control
`default_nettype wire

// ==== cff_filter_fifo_control_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
// ========================================
// checker on the block ports
module cff_filter_fifo_control_sva
	import cff_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [31:0]       wb_dat_o,
	input wire logic              wb_ack_o,
	input wire logic              rx_valid,
	input wire logic              rx_store_valid,
	input wire logic [31:0]       rx_store_addr,
	input wire logic              rx_overflow,
	input wire logic              tx_offer_valid,
	input wire logic [31:0]       tx_offer_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_base_low_zero: assert property (wb_ack_o && !$past(wb_we_i)
		&& $past(wb_adr_i) == BASE_ADDRESS_OFFSET |-> wb_dat_o[1:0] == 2'h0) else $error("base low");
	a_value_unused: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[9:7]) ==
		REGION_FILTER_VALUE |-> !wb_dat_o[20] && !wb_dat_o[18]) else $error("value gaps");
	a_ctrl_unused: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[9:7]) ==
		REGION_FIFO_CONTROL |-> {wb_dat_o[31:21], wb_dat_o[15], wb_dat_o[13], wb_dat_o[11:8]} == 17'h0)
		else $error("control gaps");
	a_store_cause: assert property (rx_store_valid || rx_overflow |-> $past(rx_valid))
		else $error("store without frame");
	a_store_aligned: assert property (rx_store_valid |-> rx_store_addr[1:0] == 2'h0)
		else $error("store misaligned");
	a_offer_aligned: assert property (tx_offer_valid |-> tx_offer_addr[1:0] == 2'h0)
		else $error("offer misaligned");
endmodule : cff_filter_fifo_control_sva
bind cff_filter_fifo_control cff_filter_fifo_control_sva chk_i (.clk, .rst, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .rx_valid, .rx_store_valid, .rx_store_addr,
	.rx_overflow, .tx_offer_valid, .tx_offer_addr);
`default_nettype wire

// ==== cff_tx_engine_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ========================================
// transmit engine facing the bus
module cff_tx_engine_model (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [1:0]  kind,
	input wire logic        tx_offer_valid,
	input wire logic [4:0]  tx_offer_fifo,
	input wire logic [31:0] tx_abort_request,
	output logic     [4:0]  tx_status_fifo,
	output logic            tx_success,
	output logic            tx_aborted,
	output logic            tx_arb_lost,
	output logic            tx_bus_error
);
	logic [2:0] cnt;
	// answer an offer at the end of its fifth cycle; kind 3 never finishes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 3'h0;
			{tx_status_fifo, tx_success, tx_aborted, tx_arb_lost, tx_bus_error} <= 9'h0;
		end else begin
			{tx_success, tx_aborted, tx_arb_lost, tx_bus_error} <= 4'h0;
			cnt <= tx_offer_valid ? cnt + 3'h1 : 3'h0;
			if (tx_abort_request != 32'h0 && !tx_aborted) begin
				for (int i = 31; i >= 0; i--) if (tx_abort_request[i]) tx_status_fifo <= 5'(i);
				tx_aborted <= 1'b1;
			end else if (cnt == 3'h4 && kind != 2'h3) begin
				tx_status_fifo <= tx_offer_fifo;
				tx_success <= 1'b1;
				tx_arb_lost <= kind == 2'h1;
				tx_bus_error <= kind == 2'h2;
				cnt <= 3'h0;
			end
		end
	end
endmodule : cff_tx_engine_model
`default_nettype wire

// ==== cff_filter_fifo_control_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
// ========================================
// self-checking bench
module cff_filter_fifo_control_tb
	import cff_pkg::*;
;
	logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_valid, rx_ide, rx_store_valid;
	logic rx_store_payload_only, rx_overflow, tx_offer_valid, tx_success, tx_aborted;
	logic tx_arb_lost, tx_bus_error, rx_rtr;
	logic [ADDR_W-1:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rx_store_addr, tx_offer_addr, tx_abort_request, q, r, bs;
	logic [10:0] rx_sid;
	logic [17:0] rx_eid;
	logic [4:0] rx_store_fifo, tx_offer_fifo, tx_status_fifo;
	logic [2:0] operating_mode_field;
	logic [1:0] kind;
	int n_fail, n_checks, i;
	cff_filter_fifo_control uut (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .operating_mode_field, .rx_valid,
		.rx_ide, .rx_rtr, .rx_sid, .rx_eid, .rx_store_valid, .rx_store_fifo,
		.rx_store_addr, .rx_store_payload_only, .rx_overflow, .tx_offer_valid, .tx_offer_fifo,
		.tx_offer_addr, .tx_abort_request, .tx_status_fifo, .tx_success, .tx_aborted,
		.tx_arb_lost, .tx_bus_error);
	cff_tx_engine_model eng (.clk, .rst, .kind, .tx_offer_valid, .tx_offer_fifo,
		.tx_abort_request, .tx_status_fifo, .tx_success, .tx_aborted, .tx_arb_lost, .tx_bus_error);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] slot(input int n);
		return bs + 32'(n) * FULL_MSG_BYTES;
	endfunction : slot
	task give_verdict;
		if (n_fail == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	// one classic single cycle, read data left in q
	task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
		for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk);
		if (wb_ack_o !== 1'b1) begin
			n_fail++;
			give_verdict;
		end else begin
			q = wb_dat_o;
			{wb_cyc_i, wb_stb_i} <= 2'h0;
			@(posedge clk);
		end
	endtask : bus
	task wr(input logic [9:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task rc(input logic [9:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rc
	task wc(input logic [9:0] a, input logic [31:0] d, input logic [31:0] e);
		wr(a, d);
		rc(a, e);
	endtask : wc
	// one received identifier, outcome looked at one cycle later
	task rx(input logic x, input logic [10:0] s, input logic st,
		input logic ov, input logic [31:0] a);
		{rx_valid, rx_ide, rx_sid} <= {1'b1, x, s};
		@(posedge clk);
		rx_valid <= 1'b0;
		@(posedge clk);
		chk(32'(rx_store_valid), 32'(st));
		chk(32'(rx_overflow), 32'(ov));
		if (st) chk({rx_store_addr[31:5] ^ a[31:5], rx_store_fifo}, {a[31:5] ^ a[31:5], 5'h0});
		if (st) chk(rx_store_addr, a);
		if (st) chk(32'(rx_store_payload_only), 32'h0);
	endtask : rx
	// clock and hang limit
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		give_verdict;
	end
	// main sequence
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, rx_valid, rx_ide, wb_adr_i, wb_dat_i} = '0;
		{rx_sid, rx_eid, rx_rtr, kind, operating_mode_field, n_fail, n_checks} = '0;
		rst = 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		r = lfsr(32'hC2AC_CD2C);
		rc(10'h200, 32'h0);
		wc(10'h200, r, 32'h0);
		operating_mode_field <= CONFIG_MODE;
		wc(10'h200, r, r & 32'hFFFF_FFFC);
		bs = r & 32'hFFFF_FFFC;
		wc(10'h100, 32'h0001_0000, 32'h0001_0000);
		wc(10'h104, 32'h0001_0083, 32'h0001_0083);
		r = lfsr(r) & 32'hFFF7_FFFF;
		rx_eid <= r[17:0];
		wc(10'h000, r, r & 32'hFFEB_FFFF);
		wr(10'h210, 32'hFFE3_FFFF);
		wr(10'h080, 32'h0000_0080);
		wc(10'h000, ~r, r & 32'hFFEB_FFFF);
		operating_mode_field <= 3'h0;
		rx(1'b0, r[31:21], 1'b1, 1'b0, slot(0));
		rx(1'b0, r[31:21] ^ 11'h400, 1'b0, 1'b0, 32'h0);
		rx(1'b1, r[31:21], 1'b0, 1'b0, 32'h0);
		rx(1'b0, r[31:21], 1'b1, 1'b0, slot(1));
		rx(1'b0, r[31:21], 1'b0, 1'b1, 32'h0);
		rc(10'h180, slot(0));
		wr(10'h100, 32'h0000_2000);
		rc(10'h180, slot(1));
		rc(10'h184, slot(2));
		wr(10'h104, 32'h0000_2083);
		rc(10'h184, slot(3));
		kind <= 2'h1;
		wr(10'h104, 32'h0000_008B);
		for (i = 0; i < 50 && tx_success !== 1'b1; i++) @(posedge clk);
		chk({27'h0, tx_offer_fifo} | 32'(tx_success) << 8, 32'h0000_0101);
		chk(tx_offer_addr, slot(2));
		repeat (3) @(posedge clk);
		rc(10'h104, 32'h0001_00A3);
		rc(10'h104, 32'h0001_0083);
		kind <= 2'h3;
		wr(10'h104, 32'h0000_2083);
		wr(10'h104, 32'h0000_008B);
		wr(10'h104, 32'h0000_0083);
		chk(tx_abort_request, 32'h0000_0002);
		repeat (4) @(posedge clk);
		rc(10'h104, 32'h0001_00C3);
		wr(10'h104, 32'h0000_4083);
		bus(1'b0, 10'h104, 32'h0);
		for (int k = 0; k < 20 && q[14] !== 1'b0; k++) bus(1'b0, 10'h104, 32'h0);
		chk(q, 32'h0001_0083);
		rc(10'h184, slot(2));
		// extended filter routed to transmit fifo 1 with auto reply on
		wr(10'h080, 32'h0000_0000);
		wr(10'h000, r | 32'h0008_0000);
		wr(10'h080, 32'h0000_0081);
		wr(10'h104, 32'h0000_0087);
		rx_rtr <= 1'b1;
		rx_eid <= ~r[17:0];
		rx(1'b1, r[31:21], 1'b0, 1'b0, 32'h0);
		rc(10'h104, 32'h0001_0087);
		rx_eid <= r[17:0];
		rx(1'b1, r[31:21], 1'b0, 1'b0, 32'h0);
		rc(10'h104, 32'h0001_008F);
		wc(10'h3F0, r, 32'h0);
		give_verdict;
	end
endmodule : cff_filter_fifo_control_tb
`default_nettype wire
